// *** core/can_store_pkg.sv ***
// Constants, field layout and state codes of the CAN message buffer store
package can_store_pkg;

  localparam int         NUM_TX      = 3;
  localparam int         TX_SLOT     = 16;
  localparam int         RX_BYTES    = 15;
  localparam int         RX_SLOTS    = 5;
  localparam int         TIMER_W     = 16;
  localparam logic [2:0] RX_DEPTH    = 3'h5;
  localparam logic [2:0] RX_LAST     = 3'h4;

  // Register byte addresses
  localparam logic [5:0] ADDR_CTRL      = 6'h00;
  localparam logic [5:0] ADDR_RX_FLAG   = 6'h01;
  localparam logic [5:0] ADDR_INT_EN    = 6'h02;
  localparam logic [5:0] ADDR_TX_FLAG   = 6'h03;
  localparam logic [5:0] ADDR_ABORT_REQ = 6'h04;
  localparam logic [5:0] ADDR_ABORT_ACK = 6'h05;
  localparam logic [5:0] ADDR_TX_SEL    = 6'h06;
  localparam logic [5:0] RX_WIN_BASE    = 6'h10;
  localparam logic [5:0] TX_WIN_BASE    = 6'h20;

  // Field positions
  localparam int CTRL_INIT_BIT = 0;
  localparam int CTRL_TIME_BIT = 1;
  localparam int CTRL_LOOP_BIT = 2;
  localparam int RXF_BIT       = 0;
  localparam int OVR_BIT       = 1;
  localparam int RX_IE_BIT     = 4;
  localparam int OVR_IE_BIT    = 5;

  // Byte positions inside a slot
  localparam logic [3:0] TX_LOCAL_PRIORITY_FIELD_IDX = 4'hD;
  localparam logic [3:0] TX_TSH_IDX  = 4'hE;
  localparam logic [3:0] TX_TSL_IDX  = 4'hF;
  localparam logic [3:0] RX_TSH_IDX  = 4'hD;
  localparam logic [3:0] RX_TSL_IDX  = 4'hE;

  // Reset values and writable masks
  localparam logic [7:0] CTRL_RST    = 8'h01;
  localparam logic [7:0] CTRL_MASK   = 8'h07;
  localparam logic [7:0] INT_EN_RST  = 8'h00;
  localparam logic [7:0] INT_EN_MASK = 8'h37;
  localparam logic [2:0] EMPTY_RST   = 3'h7;

  typedef enum logic [1:0] {
    TX_IDLE = 2'h1,
    TX_BUSY = 2'h2
  } tx_state_t;

endpackage

// *** core/tx_local_priority_field_pick.sv ***
// Local priority selection among pending transmit buffers
`timescale 1ns/1ps
module tx_local_priority_field_pick
  import can_store_pkg::*;
(
  input  wire logic [NUM_TX-1:0]      pend,
  input  wire logic [NUM_TX-1:0][7:0] local_priority_field,
  output logic                        pick_valid,
  output logic [1:0]                  pick_idx
);

  logic [7:0] best;

  // Walk from the top index down so that a tie goes to the lower index
  always_comb begin
    pick_valid = 1'b0;
    pick_idx   = 2'h0;
    best       = 8'hFF;
    for (int i = NUM_TX - 1; i >= 0; i--) begin
      if (pend[i] && (!pick_valid || local_priority_field[i] <= best)) begin // R10 R24
        pick_valid = 1'b1;
        pick_idx   = 2'(i);
        best       = local_priority_field[i];
      end
    end
  end

endmodule

// *** core/can_message_buffer_store.sv ***
// CAN transmit buffers, receive FIFO and time stamp store
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// R01 - Stamp timer into active buffer on acknowledge
// R02 - Software reads transmit stamp after empty
// R03 - Free-running bit-clock timer, no wrap flag
// R04 - Timer held zero in initialization mode
// R05 - Stamp bytes read-only, reads gated by empty
// R06 - Three transmit slots: message, priority, stamp
// R07 - Select register maps buffer into window
// R08 - Software clears empty flag to send
// R09 - Sent buffer flagged empty, transmit interrupt
// R10 - Lowest priority value wins every arbitration
// R11 - Abort request never stops frame in progress
// R12 - Granted abort sets acknowledge and empty
// R13 - Acknowledge reads one aborted, zero sent
// R14 - Five-stage FIFO, only foreground visible
// R15 - Receive slots of fifteen bytes with stamp
// R16 - Full flag only for valid foreground message
// R17 - Valid message shifted, flag and interrupt
// R18 - Software reads then clears full flag
// R19 - Invalid message discarded, background overwritten
// R20 - Own frames not stored or acknowledged
// R21 - Loopback treats own frames as foreign
// R22 - Full FIFO discards message, flags overrun
// R23 - All pending buffers compete before SOF
// R24 - Equal priority goes to lower index
// R25 - Marking ready clears abort acknowledge
module can_message_buffer_store
  import can_store_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RSTN,
  input  wire logic        CE,
  input  wire logic [5:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  input  wire logic        BIT_TICK,
  input  wire logic        SOF_REQ,
  input  wire logic        TX_DONE,
  input  wire logic        TX_ERR,
  input  wire logic        TX_LOST,
  input  wire logic [3:0]  TX_RD_IDX,
  output logic      [7:0]  TX_RD_DATA,
  output logic      [1:0]  TX_ACTIVE,
  output logic             TX_PENDING,
  input  wire logic        ACK_SEEN,
  input  wire logic        RX_WR,
  input  wire logic [3:0]  RX_IDX,
  input  wire logic [7:0]  RX_BYTE,
  input  wire logic        RX_OWN,
  input  wire logic        RX_ACCEPT,
  input  wire logic        RX_END,
  output logic             RX_ACK_EN,
  output logic      [2:0]  TX_EMPTY,
  output logic             RX_FULL,
  output logic             TX_INT,
  output logic             RX_INT,
  output logic             ERR_INT,
  output logic             INIT_MODE
);

  typedef struct packed {
    logic [7:0]                          ctrl;
    logic [7:0]                          int_en;
    logic [NUM_TX-1:0]                   empty;
    logic [NUM_TX-1:0]                   abort_req;
    logic [NUM_TX-1:0]                   abort_ack;
    logic [NUM_TX-1:0]                   sel;
    tx_state_t                           state;
    logic [1:0]                          active;
    logic [TIMER_W-1:0]                  timer;
    logic                                ovr;
    logic [2:0]                          rd_ptr;
    logic [2:0]                          wr_ptr;
    logic [2:0]                          count;
    logic [7:0]                          rdata;
    logic [7:0]                          tx_rd_data;
    logic [NUM_TX*TX_SLOT-1:0][7:0]      tx_mem; // R06
    logic [RX_SLOTS-1:0][RX_BYTES-1:0][7:0] rx_mem;
    logic [RX_BYTES-1:0][7:0]            bg;
  } store_t;

  store_t                 st_ff;
  store_t                 nxt_st;
  logic [NUM_TX-1:0]      in_prog;
  logic [NUM_TX-1:0]      grant;
  logic [NUM_TX-1:0]      pend;
  logic [NUM_TX-1:0]      tx_ready;
  logic [NUM_TX-1:0][7:0] local_priority_field;
  logic                   pick_valid;
  logic [1:0]             pick_idx;
  logic                   valid_end;
  logic                   push;
  logic                   pop;
  logic                   sel_ok;
  logic [1:0]             sel_idx;

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic [5:0] tx_addr(input logic [1:0] b, input logic [3:0] i);
    tx_addr = {b, i};
  endfunction

  function automatic logic [2:0] onehot3(input logic [1:0] i);
    onehot3 = 3'h1 << i;
  endfunction

  function automatic logic [1:0] oh_index(input logic [2:0] v);
    oh_index = v[2] ? 2'h2 : (v[1] ? 2'h1 : 2'h0);
  endfunction

  function automatic logic win_hit(input logic [5:0] a, input logic [5:0] base);
    win_hit = (a[5:4] == base[5:4]);
  endfunction

  function automatic logic [2:0] ptr_inc(input logic [2:0] p);
    ptr_inc = (p == RX_LAST) ? 3'h0 : p + 3'h1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit scheduling and receive FIFO strobes

  assign in_prog  = (st_ff.state == TX_BUSY) ? onehot3(st_ff.active) : 3'h0;
  assign grant    = st_ff.abort_req & ~st_ff.empty & ~in_prog; // R11
  assign pend     = ~st_ff.empty & ~grant; // R23
  assign tx_ready = (WR && ADDR == ADDR_TX_FLAG) ? (WDATA[NUM_TX-1:0] & st_ff.empty) : 3'h0;
  assign sel_ok   = |(st_ff.sel & st_ff.empty);
  assign sel_idx  = oh_index(st_ff.sel);

  genvar g;
  generate
    for (g = 0; g < NUM_TX; g++) begin : g_local_priority_field
      assign local_priority_field[g] = st_ff.tx_mem[tx_addr(2'(g), TX_LOCAL_PRIORITY_FIELD_IDX)];
    end
  endgenerate

  tx_local_priority_field_pick u_pick (
    .pend       (pend),
    .local_priority_field       (local_priority_field),
    .pick_valid (pick_valid),
    .pick_idx   (pick_idx)
  );

  assign valid_end = RX_END & RX_ACCEPT & (~RX_OWN | st_ff.ctrl[CTRL_LOOP_BIT]); // R20 R21
  assign push      = valid_end & (st_ff.count != RX_DEPTH);
  assign pop       = WR & (ADDR == ADDR_RX_FLAG) & WDATA[RXF_BIT] & (st_ff.count != 3'h0);

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt_st = st_ff;
    // Register writes; hardware sets below override clears
    if (WR) begin
      case (ADDR)
        ADDR_CTRL: begin
          nxt_st.ctrl = WDATA & CTRL_MASK;
        end
        ADDR_INT_EN: begin
          nxt_st.int_en = WDATA & INT_EN_MASK;
        end
        ADDR_RX_FLAG: begin
          if (WDATA[OVR_BIT]) begin
            nxt_st.ovr = 1'b0;
          end
        end
        ADDR_TX_FLAG: begin
          nxt_st.empty     = st_ff.empty & ~tx_ready; // R08
          nxt_st.abort_ack = st_ff.abort_ack & ~tx_ready; // R25
        end
        ADDR_ABORT_REQ: begin
          nxt_st.abort_req = st_ff.abort_req | (WDATA[NUM_TX-1:0] & ~st_ff.empty); // R11
        end
        ADDR_TX_SEL: begin
          nxt_st.sel = (WDATA[NUM_TX-1:0] & st_ff.empty) & (~(WDATA[NUM_TX-1:0] & st_ff.empty) + 3'h1); // R07
        end
        default: begin
          if (win_hit(ADDR, TX_WIN_BASE) && sel_ok && ADDR[3:0] <= TX_LOCAL_PRIORITY_FIELD_IDX) begin // R05 R07
            nxt_st.tx_mem[tx_addr(sel_idx, ADDR[3:0])] = WDATA;
          end
        end
      endcase
    end

    // Register reads, data valid the cycle after the strobe
    nxt_st.rdata = 8'h00;
    if (RD) begin
      case (ADDR)
        ADDR_CTRL:      nxt_st.rdata = st_ff.ctrl;
        ADDR_INT_EN:    nxt_st.rdata = st_ff.int_en;
        ADDR_RX_FLAG:   nxt_st.rdata = {6'h00, st_ff.ovr, st_ff.count != 3'h0};
        ADDR_TX_FLAG:   nxt_st.rdata = {5'h00, st_ff.empty};
        ADDR_ABORT_REQ: nxt_st.rdata = {5'h00, st_ff.abort_req};
        ADDR_ABORT_ACK: nxt_st.rdata = {5'h00, st_ff.abort_ack}; // R13
        ADDR_TX_SEL:    nxt_st.rdata = {5'h00, st_ff.sel};
        default: begin
          if (win_hit(ADDR, RX_WIN_BASE) && st_ff.count != 3'h0 && ADDR[3:0] <= RX_TSL_IDX) begin // R14
            nxt_st.rdata = st_ff.rx_mem[st_ff.rd_ptr][ADDR[3:0]];
          end else if (win_hit(ADDR, TX_WIN_BASE) && sel_ok) begin // R05
            nxt_st.rdata = st_ff.tx_mem[tx_addr(sel_idx, ADDR[3:0])];
          end
        end
      endcase
    end

    // Abort grants
    nxt_st.empty     = nxt_st.empty | grant; // R12
    nxt_st.abort_ack = nxt_st.abort_ack | grant; // R12
    nxt_st.abort_req = nxt_st.abort_req & ~grant;

    // Transmit sequencing
    case (st_ff.state)
      TX_IDLE: begin
        if (SOF_REQ && pick_valid) begin // R10 R23
          nxt_st.state  = TX_BUSY;
          nxt_st.active = pick_idx;
        end
      end
      TX_BUSY: begin
        if (TX_DONE) begin
          nxt_st.empty     = nxt_st.empty | onehot3(st_ff.active); // R09
          nxt_st.abort_req = nxt_st.abort_req & ~onehot3(st_ff.active);
          nxt_st.state     = TX_IDLE;
        end else if (TX_ERR || TX_LOST) begin
          nxt_st.state = TX_IDLE; // R10
        end
      end
      default: begin
        nxt_st.state = TX_IDLE;
      end
    endcase
    nxt_st.tx_rd_data = st_ff.tx_mem[tx_addr(st_ff.active, TX_RD_IDX)];

    // Free-running stamp timer, wraps silently
    if (st_ff.ctrl[CTRL_INIT_BIT]) begin
      nxt_st.timer = '0; // R04
    end else if (BIT_TICK) begin
      nxt_st.timer = st_ff.timer + 16'h0001; // R03
    end

    // Background buffer fill, reused by the next frame when not shifted
    if (RX_WR && RX_IDX <= RX_TSL_IDX) begin // R15 R19
      nxt_st.bg[RX_IDX] = RX_BYTE;
    end
    if (ACK_SEEN && st_ff.ctrl[CTRL_TIME_BIT]) begin // R01
      if (st_ff.state == TX_BUSY) begin
        nxt_st.tx_mem[tx_addr(st_ff.active, TX_TSH_IDX)] = st_ff.timer[15:8];
        nxt_st.tx_mem[tx_addr(st_ff.active, TX_TSL_IDX)] = st_ff.timer[7:0];
      end else begin
        nxt_st.bg[RX_TSH_IDX] = st_ff.timer[15:8];
        nxt_st.bg[RX_TSL_IDX] = st_ff.timer[7:0];
      end
    end

    // Receive FIFO
    if (push) begin // R17
      nxt_st.rx_mem[st_ff.wr_ptr] = st_ff.bg;
      nxt_st.wr_ptr = ptr_inc(st_ff.wr_ptr);
    end
    if (valid_end && !push) begin
      nxt_st.ovr = 1'b1; // R22
    end
    if (pop) begin // R18
      nxt_st.rd_ptr = ptr_inc(st_ff.rd_ptr);
    end
    case ({push, pop})
      2'h2:    nxt_st.count = st_ff.count + 3'h1;
      2'h1:    nxt_st.count = st_ff.count - 3'h1;
      default: nxt_st.count = st_ff.count;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_ff        <= '0;
      st_ff.ctrl   <= CTRL_RST;
      st_ff.int_en <= INT_EN_RST;
      st_ff.empty  <= EMPTY_RST;
      st_ff.state  <= TX_IDLE;
    end else if (CE) begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign RDATA      = st_ff.rdata;
  assign TX_RD_DATA = st_ff.tx_rd_data;
  assign TX_ACTIVE  = st_ff.active;
  assign TX_PENDING = |(~st_ff.empty);
  assign RX_ACK_EN  = ~RX_OWN | st_ff.ctrl[CTRL_LOOP_BIT]; // R20
  assign TX_EMPTY   = st_ff.empty;
  assign RX_FULL    = (st_ff.count != 3'h0); // R16
  assign TX_INT     = |(st_ff.empty & st_ff.int_en[NUM_TX-1:0]); // R09
  assign RX_INT     = RX_FULL & st_ff.int_en[RX_IE_BIT]; // R17
  assign ERR_INT    = st_ff.ovr & st_ff.int_en[OVR_IE_BIT]; // R22
  assign INIT_MODE  = st_ff.ctrl[CTRL_INIT_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  AST_TIMER_INIT: assert property (CE && st_ff.ctrl[CTRL_INIT_BIT] |=> st_ff.timer == '0) // R04
    else $error("timer not held at zero in init");
  AST_TIMER_RUN: assert property (CE && !st_ff.ctrl[CTRL_INIT_BIT] && BIT_TICK // R03
    |=> st_ff.timer == $past(st_ff.timer) + 16'h0001)
    else $error("timer did not advance on bit tick");
  AST_STAMP_TX: assert property (CE && ACK_SEEN && st_ff.ctrl[CTRL_TIME_BIT] && st_ff.state == TX_BUSY // R01
    |=> {st_ff.tx_mem[tx_addr($past(st_ff.active), TX_TSH_IDX)],
         st_ff.tx_mem[tx_addr($past(st_ff.active), TX_TSL_IDX)]} == $past(st_ff.timer))
    else $error("transmit stamp not taken");
  AST_DONE_SENT: assert property (CE && st_ff.state == TX_BUSY && TX_DONE // R09
    |=> st_ff.empty[$past(st_ff.active)] && !st_ff.abort_ack[$past(st_ff.active)] && st_ff.state == TX_IDLE)
    else $error("sent buffer not released as sent");
  AST_PICK: assert property (CE && st_ff.state == TX_IDLE && SOF_REQ && pick_valid // R10
    |=> st_ff.state == TX_BUSY && st_ff.active == $past(pick_idx) && !st_ff.empty[st_ff.active])
    else $error("arbitration did not start on picked buffer");
  AST_NO_ABORT_ACTIVE: assert property (CE && st_ff.state == TX_BUSY && !TX_DONE // R11
    |=> !st_ff.empty[$past(st_ff.active)] && !st_ff.abort_ack[$past(st_ff.active)])
    else $error("buffer in transmission was aborted");
  AST_ABORT_GRANT: assert property (CE && st_ff.abort_req[0] && !st_ff.empty[0] && !in_prog[0] // R12
    |=> st_ff.empty[0] && st_ff.abort_ack[0] && !st_ff.abort_req[0])
    else $error("abort not granted");
  AST_RX_PUSH: assert property (CE && valid_end && st_ff.count != RX_DEPTH && !pop // R17
    |=> st_ff.count == $past(st_ff.count) + 3'h1 && RX_FULL)
    else $error("valid message not shifted into fifo");
  AST_OWN_DROP: assert property (CE && RX_END && RX_OWN && !st_ff.ctrl[CTRL_LOOP_BIT] && !pop // R20
    |=> st_ff.count == $past(st_ff.count))
    else $error("own frame stored outside loopback");
  AST_OVERRUN: assert property (CE && valid_end && st_ff.count == RX_DEPTH && !pop // R22
    |=> st_ff.ovr && st_ff.count == RX_DEPTH && st_ff.wr_ptr == $past(st_ff.wr_ptr))
    else $error("overrun not flagged or message kept");

endmodule

// *** test/can_engine_model.sv ***
// Behavioural model of the CAN protocol engine facing the buffer store
`timescale 1ns/1ps
module can_engine_model (
  input  wire logic       clk,
  input  wire logic       rx_ack_en,
  input  wire logic [7:0] tx_rd_data,
  output logic            bit_tick,
  output logic            sof_req,
  output logic            tx_done,
  output logic            tx_err,
  output logic            tx_lost,
  output logic            ack_seen,
  output logic            rx_end,
  output logic            rx_wr,
  output logic      [3:0] rx_idx,
  output logic      [7:0] rx_byte,
  output logic            rx_own,
  output logic            rx_accept,
  output logic      [3:0] tx_rd_idx
);
  logic [6:0] evt;
  int         ack_cnt;

  // Event codes: 0 tick, 1 sof, 2 done, 3 error, 4 lost, 5 ack, 6 end of frame
  assign {rx_end, ack_seen, tx_lost, tx_err, tx_done, sof_req, bit_tick} = evt;

  initial begin
    evt = 7'h00;
    rx_wr = 1'b0;
    rx_idx = 4'h0;
    rx_byte = 8'h00;
    rx_own = 1'b0;
    rx_accept = 1'b0;
    tx_rd_idx = 4'h0;
    ack_cnt = 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic fire(input int k);
    @(posedge clk);
    evt <= 7'h01 << k;
    @(posedge clk);
    evt <= 7'h00;
    #1;
  endtask

  task automatic read_tx(input logic [3:0] idx, output logic [7:0] d);
    @(posedge clk);
    tx_rd_idx <= idx;
    @(posedge clk);
    #1;
    d = tx_rd_data;
  endtask

  // Bytes 0..12 into background, optional ack, end only for a good frame
  task automatic rx_frame(input logic own, input logic acc, input logic [7:0] base, input logic good);
    int i;
    @(posedge clk);
    rx_own <= own;
    rx_accept <= acc;
    for (i = 0; i < 13; i++) begin
      @(posedge clk);
      rx_wr <= 1'b1;
      rx_idx <= 4'(i);
      rx_byte <= base + 8'(i);
    end
    @(posedge clk);
    rx_wr <= 1'b0;
    rx_idx <= ~rx_idx;
    rx_byte <= ~rx_byte;
    if (rx_ack_en === 1'b1) begin
      ack_cnt++;
      fire(5);
    end
    if (good) fire(6);
    @(posedge clk);
    rx_own <= 1'b0;
    rx_accept <= 1'b0;
  endtask
endmodule

// *** test/tb.sv ***
// Self-checking bench for the CAN message buffer store
`timescale 1ns/1ps
module tb;
  import can_store_pkg::*;
  logic       clk = 1'b0;
  logic       ce, rst_n, wr, rd, tx_pending, rx_ack_en, rx_full, tx_int, rx_int, err_int, init_mode;
  logic       bit_tick, sof_req, tx_done, tx_err, tx_lost, ack_seen, rx_wr, rx_own, rx_accept, rx_end;
  logic [5:0] addr;
  logic [7:0] wdata, rdata, tx_rd_data, rx_byte, d, e;
  logic [3:0] tx_rd_idx, rx_idx;
  logic [1:0] tx_active;
  logic [2:0] tx_empty;
  logic [7:0] local_priority_field [3] = '{8'h05, 8'h02, 8'h02};
  int         ends [4] = '{3, 4, 2, 2};
  logic [1:0] want [4] = '{2'h2, 2'h2, 2'h2, 2'h0};
  int         err_total, n_checks, i, a0;

  can_message_buffer_store u_dut (
    .SYS_CLK(clk), .RSTN(rst_n), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .BIT_TICK(bit_tick), .SOF_REQ(sof_req), .TX_DONE(tx_done), .TX_ERR(tx_err), .TX_LOST(tx_lost),
    .TX_RD_IDX(tx_rd_idx), .TX_RD_DATA(tx_rd_data), .TX_ACTIVE(tx_active), .TX_PENDING(tx_pending),
    .ACK_SEEN(ack_seen), .RX_WR(rx_wr), .RX_IDX(rx_idx), .RX_BYTE(rx_byte), .RX_OWN(rx_own),
    .RX_ACCEPT(rx_accept), .RX_END(rx_end), .RX_ACK_EN(rx_ack_en), .TX_EMPTY(tx_empty), .RX_FULL(rx_full),
    .TX_INT(tx_int), .RX_INT(rx_int), .ERR_INT(err_int), .INIT_MODE(init_mode));

  can_engine_model eng (
    .clk(clk), .rx_ack_en(rx_ack_en), .tx_rd_data(tx_rd_data), .bit_tick(bit_tick), .sof_req(sof_req),
    .tx_done(tx_done), .tx_err(tx_err), .tx_lost(tx_lost), .ack_seen(ack_seen), .rx_end(rx_end),
    .rx_wr(rx_wr), .rx_idx(rx_idx), .rx_byte(rx_byte), .rx_own(rx_own), .rx_accept(rx_accept),
    .tx_rd_idx(tx_rd_idx));

  always #2 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [5:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input string nm, input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, exp, rdata);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    give_verdict();
  end

  initial begin
    ce = 1'b1;
    rst_n = 1'b0;
    addr = 6'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    err_total = 0;
    n_checks = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("tx_empty", 8'(EMPTY_RST), 8'(tx_empty));
    chk("init_mode", 8'h01, 8'(init_mode));
    rd_chk("ctrl", ADDR_CTRL, CTRL_RST);
    rd_chk("int_en", ADDR_INT_EN, INT_EN_RST);
    rd_chk("unmapped", 6'h08, 8'h00);
    // A tick in initialization mode must not advance the timer
    eng.fire(0);
    wr_reg(ADDR_INT_EN, 8'h37);
    for (i = 0; i < NUM_TX; i++) begin
      wr_reg(ADDR_TX_SEL, 8'h01 << i);
      wr_reg(TX_WIN_BASE, 8'hB0 + 8'(i));
      wr_reg(TX_WIN_BASE | 6'(TX_LOCAL_PRIORITY_FIELD_IDX), local_priority_field[i]);
      rd_chk("tx_byte", TX_WIN_BASE, 8'hB0 + 8'(i));
    end
    rd_chk("tx_sel", ADDR_TX_SEL, 8'h04);
    wr_reg(ADDR_TX_FLAG, 8'h07);
    chk("tx_empty", 8'h00, 8'(tx_empty));
    chk("tx_pending", 8'h01, 8'(tx_pending));
    chk("tx_int", 8'h00, 8'(tx_int));
    rd_chk("tx_win_busy", TX_WIN_BASE, 8'h00);
    eng.fire(1);
    chk("tx_active", 8'h01, 8'(tx_active));
    eng.read_tx(4'h0, d);
    chk("tx_rd_data", 8'hB1, d);
    eng.read_tx(TX_LOCAL_PRIORITY_FIELD_IDX, d);
    chk("tx_rd_local_priority_field", 8'h02, d);
    wr_reg(ADDR_ABORT_REQ, 8'h03);
    // The grant follows one cycle after the request is registered
    @(posedge clk);
    #1;
    chk("tx_empty", 8'h01, 8'(tx_empty));
    chk("tx_int", 8'h01, 8'(tx_int));
    rd_chk("abort_ack", ADDR_ABORT_ACK, 8'h01);
    wr_reg(ADDR_CTRL, 8'h02);
    chk("init_mode", 8'h00, 8'(init_mode));
    repeat (3) eng.fire(0);
    eng.fire(5);
    eng.fire(2);
    chk("tx_empty", 8'h03, 8'(tx_empty));
    rd_chk("abort_ack", ADDR_ABORT_ACK, 8'h01);
    rd_chk("abort_req", ADDR_ABORT_REQ, 8'h00);
    // Buffer 2 is still pending, so only buffer 1 may be selected
    wr_reg(ADDR_TX_SEL, 8'h06);
    rd_chk("tx_sel_masked", ADDR_TX_SEL, 8'h02);
    rd_chk("stamp_hi", TX_WIN_BASE | 6'(TX_TSH_IDX), 8'h00);
    rd_chk("stamp_lo", TX_WIN_BASE | 6'(TX_TSL_IDX), 8'h03);
    wr_reg(TX_WIN_BASE | 6'(TX_TSL_IDX), 8'hAA);
    rd_chk("stamp_lo_ro", TX_WIN_BASE | 6'(TX_TSL_IDX), 8'h03);
    wr_reg(ADDR_TX_FLAG, 8'h01);
    rd_chk("abort_ack", ADDR_ABORT_ACK, 8'h00);
    for (i = 0; i < 4; i++) begin
      eng.fire(1);
      chk("tx_active", 8'(want[i]), 8'(tx_active));
      eng.fire(ends[i]);
    end
    chk("tx_empty", 8'h07, 8'(tx_empty));
    chk("tx_pending", 8'h00, 8'(tx_pending));
    rd_chk("rx_win_empty", RX_WIN_BASE, 8'h00);
    eng.rx_frame(1'b0, 1'b0, 8'h90, 1'b1);
    a0 = eng.ack_cnt;
    eng.rx_frame(1'b1, 1'b1, 8'h91, 1'b1);
    chk("own_ack", 8'(a0), 8'(eng.ack_cnt));
    eng.rx_frame(1'b0, 1'b1, 8'h92, 1'b0);
    chk("rx_full", 8'h00, 8'(rx_full));
    for (i = 0; i < 6; i++) eng.rx_frame(1'b0, 1'b1, 8'(16 * (i + 1)), 1'b1);
    chk("rx_full", 8'h01, 8'(rx_full));
    chk("rx_int", 8'h01, 8'(rx_int));
    rd_chk("rx_flag", ADDR_RX_FLAG, 8'h03);
    chk("err_int", 8'h01, 8'(err_int));
    rd_chk("rx_head", RX_WIN_BASE, 8'h10);
    wr_reg(ADDR_RX_FLAG, 8'h01);
    eng.rx_frame(1'b0, 1'b1, 8'h70, 1'b1);
    wr_reg(ADDR_RX_FLAG, 8'h02);
    chk("err_int", 8'h00, 8'(err_int));
    for (i = 0; i < 5; i++) begin
      e = (i < 4) ? 8'(32 + 16 * i) : 8'h70;
      rd_chk("rx_byte0", RX_WIN_BASE, e);
      rd_chk("rx_byte12", RX_WIN_BASE + 6'h0C, e + 8'h0C);
      wr_reg(ADDR_RX_FLAG, 8'h01);
    end
    chk("rx_full", 8'h00, 8'(rx_full));
    wr_reg(ADDR_CTRL, 8'h06);
    a0 = eng.ack_cnt;
    eng.rx_frame(1'b1, 1'b1, 8'hC0, 1'b1);
    chk("loop_ack", 8'(a0 + 1), 8'(eng.ack_cnt));
    chk("rx_full", 8'h01, 8'(rx_full));
    rd_chk("loop_byte0", RX_WIN_BASE, 8'hC0);
    rd_chk("rx_stamp_lo", RX_WIN_BASE | 6'(RX_TSL_IDX), 8'h03);
    // With the clock enable low a write must not land
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(ADDR_INT_EN, 8'h00);
    chk("tx_int_frozen", 8'h01, 8'(tx_int));
    chk("rx_int_frozen", 8'h01, 8'(rx_int));
    @(posedge clk);
    ce <= 1'b1;
    wr_reg(ADDR_INT_EN, 8'h00);
    chk("tx_int_masked", 8'h00, 8'(tx_int));
    chk("rx_int_masked", 8'h00, 8'(rx_int));
    give_verdict();
  end
endmodule
